// ### psw_map.vh
/*
 Constants for the paged summary status word of a dual-channel power controller:
 command code, page codes, bit positions, detail-flag positions and reset values.
 Assumes it is included by the design files of the psw_ block only.
*/
// Summary of operation
// - Word at code 79h is read only by a two-byte Read Word transaction.
// - Page 00h returns channel A status, page 01h returns channel B status.
// - Page FFh returns channel A status on a read.
// - Bit 15 is set while any output-voltage detail flag is latched.
// - Bit 14 is set while any output-current detail flag is latched.
// - Bit 13 is set while any input detail flag is latched.
// - Bit 12 is set while any manufacturer-specific flag is latched.
// - Bits 10 to 7 are unsupported and always read zero.
// - Bit 6 is raw: set whenever the channel is not delivering power.
// - Bit 5 is set while the output over-voltage fault flag is latched.
// - Bit 4 is set while the output over-current fault flag is latched.
// - Bit 3 is set while the input under-voltage flag is latched.
// - Bit 2 is set while an over-temperature fault or warning is latched.
// - Bit 1 is set while a communication, memory or logic flag is latched.
// - Bit 0 is set for any latched output-voltage or output-current flag not shown by bits 5 and 4.
// - Summary bits other than the raw bits 11 and 6 mirror detail flags (bit 1 also the local comm latch); clearing goes through detail registers.
// - Clearing the detail over-current fault bit also clears summary bit 4.
// - Any write to the summary word is rejected and changes nothing but the comm latch.
// - Latched flags stay set until clear-faults or a write of one.
`ifndef PSW_MAP_VH
`define PSW_MAP_VH

`define PSW_CMD_SUMMARY     8'h79
`define PSW_PAGE_A          8'h00
`define PSW_PAGE_B          8'h01
`define PSW_PAGE_ALL        8'hff

`define PSW_PROT_BYTE       2'h0
`define PSW_PROT_WORD       2'h1
`define PSW_PROT_BLOCK      2'h2

`define PSW_BIT_VOUT        15
`define PSW_BIT_IOUT        14
`define PSW_BIT_INPUT       13
`define PSW_BIT_MFR         12
`define PSW_BIT_PGOOD       11
`define PSW_BIT_OFF         6
`define PSW_BIT_VOUT_OV     5
`define PSW_BIT_IOUT_OC     4
`define PSW_BIT_VIN_UV      3
`define PSW_BIT_TEMP        2
`define PSW_BIT_CML         1
`define PSW_BIT_OTHER       0

`define PSW_VOUT_OVF_BIT    7
`define PSW_IOUT_OCF_BIT    7
`define PSW_INPUT_UV_BIT    4

`define PSW_WORD_RST        16'h0000
`define PSW_SYNC_RST        1'h0

`endif

// ### psw_sync.v
/*
 Two-stage synchroniser for levels arriving from pins.
 Assumes the inputs are asynchronous to i_clk and only levels matter.
*/
`default_nettype none
`include "psw_map.vh"

module psw_sync #(
    parameter WIDTH = 2
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage is read only by the second stage
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_q <= {WIDTH{`PSW_SYNC_RST}};
            sync_q <= {WIDTH{`PSW_SYNC_RST}};
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule
`default_nettype wire

// ### psw_chan.v
/*
 Summary word builder for one channel: folds the latched detail flag bytes,
 the raw output-off state and the synchronised ready pin into 16 bits.
 Assumes all inputs are on the system clock; purely combinational.
*/
`default_nettype none
`include "psw_map.vh"

module psw_chan (
    input  wire [7:0]  i_vout_stat,
    input  wire [7:0]  i_iout_stat,
    input  wire [7:0]  i_input_stat,
    input  wire [7:0]  i_mfr_stat,
    input  wire [7:0]  i_temp_stat,
    input  wire [7:0]  i_cml_stat,
    input  wire        i_cml_local,
    input  wire        i_power_on,
    input  wire        i_ready_sync,
    output reg  [15:0] o_word
);

    reg [7:0] vout_rest;
    reg [7:0] iout_rest;

    // Bits other than 11 and 6 mirror their detail flags (bit 1 also the local latch), so detail clears show here at once
    always @*
    begin
        vout_rest = i_vout_stat;
        iout_rest = i_iout_stat;
        vout_rest[`PSW_VOUT_OVF_BIT] = 1'b0;
        iout_rest[`PSW_IOUT_OCF_BIT] = 1'b0;
        o_word = `PSW_WORD_RST;
        o_word[`PSW_BIT_VOUT] = |i_vout_stat;
        o_word[`PSW_BIT_IOUT] = |i_iout_stat;
        o_word[`PSW_BIT_INPUT] = |i_input_stat;
        o_word[`PSW_BIT_MFR] = |i_mfr_stat;
        o_word[`PSW_BIT_PGOOD] = ~i_ready_sync;
        o_word[`PSW_BIT_OFF] = ~i_power_on;
        o_word[`PSW_BIT_VOUT_OV] = i_vout_stat[`PSW_VOUT_OVF_BIT];
        o_word[`PSW_BIT_IOUT_OC] = i_iout_stat[`PSW_IOUT_OCF_BIT];
        o_word[`PSW_BIT_VIN_UV] = i_input_stat[`PSW_INPUT_UV_BIT];
        o_word[`PSW_BIT_TEMP] = |i_temp_stat;
        o_word[`PSW_BIT_CML] = (|i_cml_stat) | i_cml_local;
        // Under-voltage fault, over-current warning and the like land here
        o_word[`PSW_BIT_OTHER] = (|vout_rest) | (|iout_rest);
    end

endmodule
`default_nettype wire

// ### psw_top.v
/*
 Paged summary status word. Answers the PMBus transaction layer for code 79h:
 a Read Word returns the selected channel's 16-bit summary, anything else
 addressed to the word is rejected and latches a communication flag.
 The word is folded from the detail flag bytes one channel at a time in
 psw_chan; this module picks the channel, registers the answer and keeps
 the local comm latch that a refused access sets.
 Timing: the answer and the reject strobe come out of flops just after the taking
 edge and last one clock; the read data holds until the next legal read.
 The live copies trail their inputs by one clock, and the ready bit trails
 its pin by three because of the synchroniser.
 Limitations: a refused write touches nothing but the comm latch; pages
 other than 00h, 01h and FFh are refused for reads, while a clear-faults
 on them acts on channel A.
 Assumes the transaction layer, page register and detail status registers are
 on I_MCLK; only the two ready pins come from outside and are synchronised.
 Assumes the layer splits the word into bus bytes, low byte first, and that
 the detail registers clear their own flags on a write of one.
*/
`default_nettype none
`include "psw_map.vh"

module psw_top (
    input  wire        I_MCLK,
    input  wire        I_NRST,
    // Transaction layer, one request per pulse
    input  wire        I_CMD_VALID,
    input  wire [7:0]  I_CMD_CODE,
    input  wire        I_CMD_WR,
    input  wire [1:0]  I_CMD_PROT,
    input  wire [7:0]  I_PAGE,
    // Fault clearing from the command decoder
    input  wire        I_CLEAR_FAULTS,
    input  wire        I_CML_CLR_A,
    input  wire        I_CML_CLR_B,
    // Channel A latched detail flags
    input  wire [7:0]  I_A_VOUT_STAT,
    input  wire [7:0]  I_A_IOUT_STAT,
    input  wire [7:0]  I_A_INPUT_STAT,
    input  wire [7:0]  I_A_MFR_STAT,
    input  wire [7:0]  I_A_TEMP_STAT,
    input  wire [7:0]  I_A_CML_STAT,
    input  wire        I_A_POWER_ON,
    // Channel B latched detail flags
    input  wire [7:0]  I_B_VOUT_STAT,
    input  wire [7:0]  I_B_IOUT_STAT,
    input  wire [7:0]  I_B_INPUT_STAT,
    input  wire [7:0]  I_B_MFR_STAT,
    input  wire [7:0]  I_B_TEMP_STAT,
    input  wire [7:0]  I_B_CML_STAT,
    input  wire        I_B_POWER_ON,
    // Ready pins, asynchronous
    input  wire        I_CHAN_A_READY_PIN,
    input  wire        I_CHAN_B_READY_PIN,
    // Answers
    output wire        O_RD_VALID,
    output wire [15:0] O_RD_DATA,
    output wire        O_CMD_INVALID,
    // Comm latch and live copies for the alert logic
    output wire [1:0]  O_CML_LATCH,
    output wire [15:0] O_STATUS_A,
    output wire [15:0] O_STATUS_B
);

    wire [1:0]  ready_sync;
    wire [15:0] word_a;
    wire [15:0] word_b;

    // Answer, latch and copy registers with their next values
    reg         rd_valid_q;
    reg         rd_valid_d;
    reg [15:0]  rd_data_q;
    reg [15:0]  rd_data_d;
    reg         invalid_q;
    reg         invalid_d;
    reg [1:0]   cml_q;
    reg [1:0]   cml_d;
    reg [15:0]  stat_a_q;
    reg [15:0]  stat_b_q;

    // Decoded request, all combinational
    reg         hit;
    reg         page_a;
    reg         page_b;
    reg         page_all;
    reg         page_ok;
    reg         rd_ok;
    reg         rd_bad;
    reg [1:0]   cml_set;
    reg [1:0]   cml_clr;

    // Pins cross into the clock domain before anything looks at them.
    // Reset value 0 makes the power-good bit read 1 until the pins settle.
    psw_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_clk   (I_MCLK),
        .i_rst_n (I_NRST),
        .i_async ({I_CHAN_B_READY_PIN, I_CHAN_A_READY_PIN}),
        .o_sync  (ready_sync)
    );

    // Channel A summary, folded from its own flag bytes;
    // its comm bit also carries the local latch
    psw_chan u_chan_a (
        .i_vout_stat  (I_A_VOUT_STAT),
        .i_iout_stat  (I_A_IOUT_STAT),
        .i_input_stat (I_A_INPUT_STAT),
        .i_mfr_stat   (I_A_MFR_STAT),
        .i_temp_stat  (I_A_TEMP_STAT),
        .i_cml_stat   (I_A_CML_STAT),
        .i_cml_local  (cml_q[0]),
        .i_power_on   (I_A_POWER_ON),
        .i_ready_sync (ready_sync[0]),
        .o_word       (word_a)
    );

    // Channel B summary, built exactly like channel A
    // so both pages answer with the same bit meanings
    psw_chan u_chan_b (
        .i_vout_stat  (I_B_VOUT_STAT),
        .i_iout_stat  (I_B_IOUT_STAT),
        .i_input_stat (I_B_INPUT_STAT),
        .i_mfr_stat   (I_B_MFR_STAT),
        .i_temp_stat  (I_B_TEMP_STAT),
        .i_cml_stat   (I_B_CML_STAT),
        .i_cml_local  (cml_q[1]),
        .i_power_on   (I_B_POWER_ON),
        .i_ready_sync (ready_sync[1]),
        .o_word       (word_b)
    );

    // Page decode. Pages other than 00h, 01h and FFh select nothing, so a
    // read there is refused rather than guessed at.
    always @*
    begin
        page_a   = (I_PAGE == `PSW_PAGE_A);
        page_b   = (I_PAGE == `PSW_PAGE_B);
        page_all = (I_PAGE == `PSW_PAGE_ALL);
        page_ok  = page_a || page_b || page_all;
    end

    // Request decode: only a read with the word protocol is legal.
    // Byte and block reads of this code are refused, not cut or padded.
    always @*
    begin
        hit    = I_CMD_VALID && (I_CMD_CODE == `PSW_CMD_SUMMARY);
        rd_ok  = hit && !I_CMD_WR
                 && (I_CMD_PROT == `PSW_PROT_WORD) && page_ok;
        rd_bad = hit && !rd_ok;
    end

    // Answer strobes: exactly one of them follows every request for this code
    always @*
    begin
        rd_valid_d = rd_ok;
        invalid_d  = rd_bad;
    end

    // Read data is a snapshot taken at the request; page FFh reads channel A
    always @*
    begin
        rd_data_d = rd_data_q;
        if (rd_ok)
        begin
            if (page_b)
            begin
                rd_data_d = word_b;
            end
            else
            begin
                rd_data_d = word_a;
            end
        end
    end

    // Which channel a rejected access charges. A write with page FFh
    // addresses both channels, so both are charged; a bad read there
    // only charges channel A, the channel that a read would answer for.
    always @*
    begin
        cml_set = 2'h0;
        if (rd_bad)
        begin
            cml_set[0] = !page_b;
            cml_set[1] = page_b || (page_all && I_CMD_WR);
        end
    end

    // Which channel a clear reaches. Clear-faults follows the page like a
    // write; an unknown page falls back to channel A. A one written to the
    // detail comm flag of a channel clears this copy as well.
    always @*
    begin
        cml_clr = 2'h0;
        if (I_CLEAR_FAULTS)
        begin
            cml_clr[0] = !page_b;
            cml_clr[1] = page_b || page_all;
        end
        cml_clr[0] = cml_clr[0] | I_CML_CLR_A;
        cml_clr[1] = cml_clr[1] | I_CML_CLR_B;
    end

    // A set in the same cycle as a clear wins, so no event is lost
    always @*
    begin
        cml_d = cml_set | (cml_q & ~cml_clr);
    end

    // Read answer strobe: one pulse per legal read, low again the next clock
    always @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= rd_valid_d;
        end
    end

    // Read data holds between reads, so a slow layer may serialise it late;
    // the cost is sixteen flops that a live mux would not need
    always @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            rd_data_q <= `PSW_WORD_RST;
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    // Reject strobe: one pulse per refused access, never with a read answer
    always @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            invalid_q <= 1'b0;
        end
        else
        begin
            invalid_q <= invalid_d;
        end
    end

    // Local comm latch, bit 0 for channel A and bit 1 for channel B.
    // It is the only latch kept here; the detail bytes live outside.
    always @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            cml_q <= 2'h0;
        end
        else
        begin
            cml_q <= cml_d;
        end
    end

    // Live copy of channel A for the alert and fault logic. It trails the
    // flag inputs by one clock and a ready pin change by three.
    always @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            stat_a_q <= `PSW_WORD_RST;
        end
        else
        begin
            stat_a_q <= word_a;
        end
    end

    // Live copy of channel B, with the same timing as channel A
    always @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            stat_b_q <= `PSW_WORD_RST;
        end
        else
        begin
            stat_b_q <= word_b;
        end
    end

    // Answers to the transaction layer, straight from flip-flops
    assign O_RD_VALID    = rd_valid_q;
    assign O_RD_DATA     = rd_data_q;
    assign O_CMD_INVALID = invalid_q;

    // Latch and live copies, straight from flip-flops
    assign O_CML_LATCH   = cml_q;
    assign O_STATUS_A    = stat_a_q;
    assign O_STATUS_B    = stat_b_q;

endmodule
`default_nettype wire

// ### psw_props.sv
/* Checker for the paged summary status word.
   Assumes it sees only the top ports, on one clock. */
`default_nettype none
module psw_props (
    input wire logic        I_MCLK,
    input wire logic        I_NRST,
    input wire logic        I_CMD_VALID,
    input wire logic [7:0]  I_CMD_CODE,
    input wire logic        I_CMD_WR,
    input wire logic [1:0]  I_CMD_PROT,
    input wire logic [7:0]  I_PAGE,
    input wire logic        I_A_POWER_ON,
    input wire logic [7:0]  I_A_IOUT_STAT,
    input wire logic [7:0]  I_B_VOUT_STAT,
    input wire logic        O_RD_VALID,
    input wire logic [15:0] O_RD_DATA,
    input wire logic        O_CMD_INVALID,
    input wire logic [1:0]  O_CML_LATCH,
    input wire logic [15:0] O_STATUS_A,
    input wire logic [15:0] O_STATUS_B
);
    timeunit 1ns;
    timeprecision 1ns;

    // Request decode; pg_a covers page FFh too
    wire hit  = I_CMD_VALID && I_CMD_CODE == 8'h79;
    wire rd   = hit && !I_CMD_WR && I_CMD_PROT == 2'h1;
    wire pg_a = I_PAGE == 8'h00 || I_PAGE == 8'hff;
    wire oc   = I_A_IOUT_STAT[7];
    wire vb   = |I_B_VOUT_STAT;

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_NRST);

    one_answer_a: assert property (!(O_RD_VALID && O_CMD_INVALID))
        else $error("read and reject together");
    rd_answer_a: assert property (rd && (pg_a || I_PAGE == 8'h01) |=> O_RD_VALID)
        else $error("legal read not answered");
    page_b_a: assert property (rd && I_PAGE == 8'h01 |=> O_RD_DATA == O_STATUS_B)
        else $error("page one not channel B");
    page_a_a: assert property (rd && pg_a |=> O_RD_DATA == O_STATUS_A)
        else $error("page zero or all not channel A");
    write_reject_a: assert property (hit && I_CMD_WR |=> O_CMD_INVALID
        && $stable(O_RD_DATA) && O_CML_LATCH != 2'h0)
        else $error("write not rejected");
    bad_read_a: assert property (hit && !I_CMD_WR && !(rd && (pg_a || I_PAGE == 8'h01))
        |=> O_CMD_INVALID && !O_RD_VALID && $stable(O_RD_DATA))
        else $error("bad read not rejected");
    unsup_zero_a: assert property (O_STATUS_A[10:7] == 4'h0 && O_STATUS_B[10:7] == 4'h0)
        else $error("unsupported bits set");
    off_raw_a: assert property ($past(I_NRST) |-> O_STATUS_A[6] == !$past(I_A_POWER_ON))
        else $error("off bit wrong");
    oc_mirror_a: assert property ($past(I_NRST) |-> O_STATUS_A[4] == $past(oc))
        else $error("overcurrent bit wrong");
    vout_mirror_a: assert property ($past(I_NRST) |-> O_STATUS_B[15] == $past(vb))
        else $error("voltage summary wrong");
    rd_hold_a: assert property ($past(I_NRST) && !O_RD_VALID |-> $stable(O_RD_DATA))
        else $error("read data moved");
endmodule

bind psw_top psw_props i_props (.*);
`default_nettype wire

// ### psw_host.sv
/* Host transaction layer model for the summary word.
   Assumes the block answers from flops just after the taking edge. */
`default_nettype none
module psw_host (
    input  wire logic       i_clk,
    output var  logic       o_valid,
    output var  logic [7:0] o_code,
    output var  logic       o_wr,
    output var  logic [1:0] o_prot,
    output var  logic [7:0] o_page
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle values; code stays on the word so only page and kind vary
    initial
    begin
        {o_valid, o_wr, o_prot, o_page} = '0;
        o_code = 8'h79;
    end

    // One request held to its taking edge; caller samples the answer just after
    task automatic xfer(input logic [7:0] pg, input logic w, input logic [1:0] pr);
        @(posedge i_clk);
        o_page  <= pg;
        o_wr    <= w;
        o_prot  <= pr;
        o_valid <= 1'b1;
        @(posedge i_clk);
        o_valid <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// ### tb_pmbus_status_summary_word.sv
/* Self-checking bench for the paged summary status word.
   Assumes psw_host drives requests and the bench owns the detail flags. */
`default_nettype none
module tb_pmbus_status_summary_word;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, nrst, valid, wr, a_on, b_on, rdy_a, rdy_b;
    logic        clr, cla, clb, rd_v, inv;
    logic [1:0]  prot, cml;
    logic [7:0]  code, page;
    logic [15:0] rd_d, sb, sa;
    logic [47:0] a_st, b_st;
    int          fail_count, checks, n;

    // Detail bytes packed as vout, iout, input, mfr, temp, cml
    localparam logic [47:0] st_t [8] = '{48'h8000_0000_0000, 48'h1000_0000_0000,
        48'h0080_0000_0000, 48'h0020_0000_0000, 48'h0000_1000_0000,
        48'h0000_0001_0000, 48'h0000_0000_0100, 48'h0000_0000_0002};
    localparam logic [15:0] ex_t [8] = '{16'h8020, 16'h8001, 16'h4010, 16'h4001,
        16'h2008, 16'h1000, 16'h0004, 16'h0002};

    psw_host i_host (.i_clk(clk), .o_valid(valid), .o_code(code), .o_wr(wr),
        .o_prot(prot), .o_page(page));

    psw_top i_dut (.I_MCLK(clk), .I_NRST(nrst), .I_CMD_VALID(valid),
        .I_CMD_CODE(code), .I_CMD_WR(wr), .I_CMD_PROT(prot), .I_PAGE(page),
        .I_CLEAR_FAULTS(clr), .I_CML_CLR_A(cla), .I_CML_CLR_B(clb),
        .I_A_VOUT_STAT(a_st[47:40]), .I_A_IOUT_STAT(a_st[39:32]),
        .I_A_INPUT_STAT(a_st[31:24]), .I_A_MFR_STAT(a_st[23:16]),
        .I_A_TEMP_STAT(a_st[15:8]), .I_A_CML_STAT(a_st[7:0]), .I_A_POWER_ON(a_on),
        .I_B_VOUT_STAT(b_st[47:40]), .I_B_IOUT_STAT(b_st[39:32]),
        .I_B_INPUT_STAT(b_st[31:24]), .I_B_MFR_STAT(b_st[23:16]),
        .I_B_TEMP_STAT(b_st[15:8]), .I_B_CML_STAT(b_st[7:0]), .I_B_POWER_ON(b_on),
        .I_CHAN_A_READY_PIN(rdy_a), .I_CHAN_B_READY_PIN(rdy_b),
        .O_RD_VALID(rd_v), .O_RD_DATA(rd_d), .O_CMD_INVALID(inv),
        .O_CML_LATCH(cml), .O_STATUS_A(sa), .O_STATUS_B(sb));

    // Free-running 10 MHz clock
    always #50 clk = ~clk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Legal read of the word; the answer must be a read pulse, never a reject
    task automatic rd_chk(input logic [7:0] pg, input logic [15:0] exp);
        i_host.xfer(pg, 1'b0, 2'h1);
        check({14'h0, rd_v, inv}, 16'h0002);
        check(rd_d, exp);
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One flag at a time on each channel; channel A read through pages 00h and FFh, channel B through page 01h
    task automatic t_bits;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk) a_st <= st_t[i];
            rd_chk(8'h00, ex_t[i]);
            rd_chk(8'hff, ex_t[i]);
            rd_chk(8'h01, 16'h0000);
            @(posedge clk) a_st <= '0;
            @(posedge clk) b_st <= st_t[i];
            rd_chk(8'h01, ex_t[i]);
            @(posedge clk) b_st <= '0;
        end
    endtask

    // Bounded wait, between edges, until the live words show ready bits {B, A}
    task automatic wait_pg(input logic [1:0] want);
        for (n = 0; n < 8 && {sb[11], sa[11]} !== want; n++)
            @(negedge clk);
        if (n == 8)
        begin
            fail_count++;
            $display("Error %0t: ready pin never seen", $time);
            give_verdict;
        end
    endtask

    // Raw bits: output off and ready pin low, one channel at a time
    task automatic t_raw;
        @(posedge clk) {a_on, b_on, rdy_a, rdy_b} <= 4'ha;
        wait_pg(2'b10);
        check(sa, 16'h0000);
        rd_chk(8'h01, 16'h0840);
        rd_chk(8'h00, 16'h0000);
        @(posedge clk) {a_on, b_on, rdy_a, rdy_b} <= 4'h5;
        wait_pg(2'b01);
        check(sb, 16'h0000);
        rd_chk(8'h00, 16'h0840);
        @(posedge clk) {a_on, b_on, rdy_a, rdy_b} <= 4'hf;
        repeat (3) @(posedge clk);
    endtask

    // Unknown page read, page FFh and channel B writes, clear-faults on each of those pages and the channel B comm clear
    task automatic t_page;
        i_host.xfer(8'h05, 1'b0, 2'h1);
        check({14'h0, rd_v, inv}, 16'h0001);
        check({14'h0, cml}, 16'h0001);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        #1 check({14'h0, cml}, 16'h0000);
        i_host.xfer(8'hff, 1'b1, 2'h1);
        check({14'h0, rd_v, inv}, 16'h0001);
        check({14'h0, cml}, 16'h0003);
        rd_chk(8'h01, 16'h0002);
        @(posedge clk) clb <= 1'b1;
        @(posedge clk) clb <= 1'b0;
        rd_chk(8'h01, 16'h0000);
        rd_chk(8'hff, 16'h0002);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        #1 check({14'h0, cml}, 16'h0000);
        i_host.xfer(8'h01, 1'b1, 2'h1);
        check({14'h0, cml}, 16'h0002);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        #1 check({14'h0, cml}, 16'h0000);
    endtask

    // Detail clear drops the overcurrent summary bit with it
    task automatic t_oc;
        @(posedge clk) a_st <= 48'h0080_0000_0000;
        rd_chk(8'h00, 16'h4010);
        @(posedge clk) a_st <= '0;
        rd_chk(8'h00, 16'h0000);
    endtask

    // Writes and wrong protocols are refused and latch the comm flag
    task automatic t_write;
        @(posedge clk) a_st <= 48'h0000_0001_0000;
        rd_chk(8'h00, 16'h1000);
        i_host.xfer(8'h00, 1'b1, 2'h1);
        check({14'h0, rd_v, inv}, 16'h0001);
        check(rd_d, 16'h1000);
        @(posedge clk) a_st <= '0;
        rd_chk(8'h00, 16'h0002);
        @(posedge clk) cla <= 1'b1;
        @(posedge clk) cla <= 1'b0;
        rd_chk(8'h00, 16'h0000);
        for (int p = 0; p < 3; p += 2)
        begin
            i_host.xfer(8'h00, 1'b0, p[1:0]);
            check({14'h0, rd_v, inv}, 16'h0001);
        end
        rd_chk(8'h00, 16'h0002);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        rd_chk(8'h00, 16'h0000);
    endtask

    // Reset, let the ready pins settle through the synchroniser, run scenarios
    initial
    begin
        {clk, nrst, clr, cla, clb, a_st, b_st} = '0;
        {a_on, b_on, rdy_a, rdy_b} = 4'hf;
        {fail_count, checks} = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_bits;
        t_raw;
        t_oc;
        t_write;
        t_page;
        give_verdict;
    end
endmodule
`default_nettype wire
